// ### src/i2c_status_pkg.sv
package i2c_status_pkg;
    // register indices; each equals its byte offset from the base
    localparam logic [3:0] IDX_ADDR_ONE  = 4'h0;
    localparam logic [3:0] IDX_ADDR_TWO  = 4'h1;
    localparam logic [3:0] IDX_CTRL_ONE  = 4'h2;
    localparam logic [3:0] IDX_STAT_ONE  = 4'h3;
    localparam logic [3:0] IDX_DATA      = 4'h4;
    localparam logic [3:0] IDX_CTRL_TWO  = 4'h5;
    localparam logic [3:0] IDX_SYS_MGMT  = 4'h6;
    localparam logic [3:0] IDX_SPAN      = 4'h7;
    // control one fields
    localparam int C1_ENABLE = 7;
    localparam int C1_TX     = 4;
    localparam int C1_WAKE   = 1;
    localparam int C1_DMA    = 0;
    // control two fields
    localparam int C2_GCALL  = 7;
    localparam int C2_RANGE  = 3;
    // system management fields
    localparam int SM_FAST_ACK_NACK_MODE   = 7;
    localparam int SM_ALERT  = 6;
    localparam int SM_SECOND = 5;
    // status one fields
    localparam int S1_TCF    = 7;
    localparam int S1_ADDRESSED_AS_TARGET_FLAG   = 6;
    localparam int S1_BUSY   = 5;
    localparam int S1_ARBITRATION_LOST_FLAG   = 4;
    localparam int S1_RAM    = 3;
    localparam int S1_SRW    = 2;
    localparam int S1_IRQ    = 1;
    localparam int S1_RECEIVED_ACK_FLAG   = 0;
    // reset values
    localparam logic [7:0] RST_REG8 = 8'h00;
    localparam logic       RST_TCF  = 1'b1;
    // fixed bus addresses (7-bit)
    localparam logic [6:0] GENERAL_CALL_ADDR   = 7'h00;
    localparam logic [6:0] ALERT_RESPONSE_ADDR = 7'h0C;
endpackage

// ### src/i2c_status_dma_wakeup_flags.sv
// Decided for this implementation: the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - wake enabled: address match wakes system
// - wake disabled: no wake on match
// - dma enable clear: no dma request
// - fast_ack_nack_mode 0: request on rx data, tx bytes
// - fast_ack_nack_mode 0: request on primary/general-call match
// - address match sets target and complete flags
// - fast_ack_nack_mode 1: request on data transmit only
// - complete flag bit7, zero during transfer
// - data read rx / write tx clears complete
// - target flag bit6: primary or span match
// - general call accepted sets target flag
// - second address match sets target flag
// - alert response address sets target flag
// - range enabled: in-range address sets target
// - target flag before ack; software sets direction
// - control one write clears target flag
// - busy bit5: start sets, stop clears
// - arbitration lost bit4, write one clears
// - status one decoded at index 3
// - range flag bit3: span or range match
// - control one write clears range flag
// - direction bit copies calling read/write bit
module i2c_status_dma_wakeup_flags
    import i2c_status_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        srst,
    // classic wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [5:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // bus pins, sampled only
    input  wire logic        sclIn,
    input  wire logic        sdaIn,
    // shift engine side, same clock
    input  wire logic        byteStart,
    input  wire logic        addrValid,
    input  wire logic [7:0]  callAddr,
    input  wire logic        rxDataDone,
    input  wire logic        txByteDone,
    input  wire logic        arbLost,
    input  wire logic [7:0]  rxData,
    input  wire logic        moduleIrq,
    input  wire logic        receivedAck,
    input  wire logic        lowPower,
    output logic      [7:0]  txData,
    output logic             txLoad,
    output logic             transmitMode,
    output logic             moduleEnable,
    output logic             fastAckMode,
    output logic             addressMatched,
    output logic             dmaRequest,
    output logic             wakeRequest
);

    // software registers
    // reset clears them all; no field holds a nonzero default
    logic [7:0] addrOne;
    logic [7:0] addrTwo;
    logic [7:0] ctrlOne;
    logic [7:0] ctrlTwo;
    logic [7:0] sysMgmt;
    logic [7:0] spanAddr;

    // status flags
    // each held in its own flop so set and clear stay local
    logic       xferDone;
    logic       targetHit;
    logic       busBusy;
    logic       arbFlag;
    logic       rangeHit;
    logic       dirBit;

    // pin synchronisers and history
    // idle level is high, so reset loads ones: no false edge
    logic       sclMeta;
    logic       sclSync;
    logic       sdaMeta;
    logic       sdaSync;
    logic       sclLast;
    logic       sdaLast;

    // bus decode; registers sit at byte offsets 0..7
    // one byte per bus word, data always on lane 0
    logic       busReq;
    logic       inWindow;
    logic       wrStrobe;
    logic       rdStrobe;
    logic [3:0] regIdx;
    logic [7:0] rdMux;
    logic [7:0] next_rdData;

    // address comparison results
    // all combinational; only meaningful while addrValid is high
    logic       primaryHit;
    logic       gcallHit;
    logic       secondHit;
    logic       alertHit;
    logic       spanHit;
    logic       inRange;
    logic       anyHit;
    logic       startSeen;
    logic       stopSeen;

    // upper 7 bits of an address register hold the 7-bit address
    function automatic logic addrEq(input logic [7:0] a, input logic [7:0] b);
        addrEq = (a[7:1] == b[7:1]);
    endfunction

    // write to a given register index with low byte lane selected
    // writes with lane 0 off are dropped, only the strobe remains
    function automatic logic hitWr(input logic [3:0] idx);
        hitWr = wrStrobe && (regIdx == idx) && wb_sel_i[0];
    endfunction

    // any write to an index, lane mask ignored
    function automatic logic anyWr(input logic [3:0] idx);
        anyWr = wrStrobe && (regIdx == idx);
    endfunction

    // a request is served in the cycle before ack rises
    // the ack cycle itself is idle, so two requests never merge
    assign busReq   = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wrStrobe = busReq && wb_we_i;
    assign rdStrobe = busReq && !wb_we_i;
    // byte offsets 16 and above fold onto an unmapped index
    // so they read zero and take no write, never alias a register
    assign inWindow = (wb_adr_i[5:4] == 2'b00);
    assign regIdx   = inWindow ? wb_adr_i[3:0] : 4'hF;

    // ack one cycle after the strobe, dropped the cycle after
    // masking the request with ack keeps a held strobe from
    // being served twice
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= busReq;
        end
    end

    // read mux; unmapped indices read as zero
    // status bits 1 and 0 pass straight from the engine
    always_comb begin
        rdMux = RST_REG8;
        case (regIdx)
            IDX_ADDR_ONE: rdMux = addrOne;
            IDX_ADDR_TWO: rdMux = addrTwo;
            IDX_CTRL_ONE: rdMux = ctrlOne;
            IDX_STAT_ONE: begin
                rdMux[S1_TCF]  = xferDone;
                rdMux[S1_ADDRESSED_AS_TARGET_FLAG] = targetHit;
                rdMux[S1_BUSY] = busBusy;
                rdMux[S1_ARBITRATION_LOST_FLAG] = arbFlag;
                rdMux[S1_RAM]  = rangeHit;
                rdMux[S1_SRW]  = dirBit;
                rdMux[S1_IRQ]  = moduleIrq;
                rdMux[S1_RECEIVED_ACK_FLAG] = receivedAck;
            end
            IDX_DATA:     rdMux = rxData;
            IDX_CTRL_TWO: rdMux = ctrlTwo;
            IDX_SYS_MGMT: rdMux = sysMgmt;
            IDX_SPAN:     rdMux = spanAddr;
            default:      rdMux = RST_REG8;
        endcase
        next_rdData = rdStrobe ? rdMux : RST_REG8;
    end

    // read data registered alongside ack; upper bits zero
    // zero outside the answer so stale bytes never leak
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            wb_dat_o <= 32'h00000000;
        end else begin
            wb_dat_o <= {24'h000000, next_rdData};
        end
    end

    // plain read/write registers; status one has no stored write bits
    // a write to index 3 only reaches the w1c logic below
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            addrOne  <= RST_REG8;
            addrTwo  <= RST_REG8;
            ctrlOne  <= RST_REG8;
            ctrlTwo  <= RST_REG8;
            sysMgmt  <= RST_REG8;
            spanAddr <= RST_REG8;
        end else begin
            if (hitWr(IDX_ADDR_ONE)) addrOne <= wb_dat_i[7:0];
            if (hitWr(IDX_ADDR_TWO)) addrTwo <= wb_dat_i[7:0];
            if (hitWr(IDX_CTRL_ONE)) ctrlOne <= wb_dat_i[7:0];
            if (hitWr(IDX_CTRL_TWO)) ctrlTwo <= wb_dat_i[7:0];
            if (hitWr(IDX_SYS_MGMT)) sysMgmt <= wb_dat_i[7:0];
            if (hitWr(IDX_SPAN))     spanAddr <= wb_dat_i[7:0];
        end
    end

    // transmit data handed to the shift engine
    // load pulse lets the engine start without polling
    // data is latched whatever the direction bit says
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            txData <= RST_REG8;
            txLoad <= 1'b0;
        end else begin
            txLoad <= hitWr(IDX_DATA);
            if (hitWr(IDX_DATA)) txData <= wb_dat_i[7:0];
        end
    end

    assign transmitMode = ctrlOne[C1_TX];
    assign moduleEnable = ctrlOne[C1_ENABLE];
    assign fastAckMode  = sysMgmt[SM_FAST_ACK_NACK_MODE];

    // address comparisons on the calling address byte
    // bit 0 of the calling byte is direction, never compared
    // a zero span register disables its own match
    assign primaryHit = addrEq(callAddr, addrOne);
    assign spanHit    = (spanAddr[7:1] != 7'h00) && addrEq(callAddr, spanAddr);
    assign gcallHit   = ctrlTwo[C2_GCALL] && (callAddr[7:1] == GENERAL_CALL_ADDR);
    assign secondHit  = sysMgmt[SM_SECOND] && addrEq(callAddr, addrTwo);
    assign alertHit   = sysMgmt[SM_ALERT] && (callAddr[7:1] == ALERT_RESPONSE_ADDR);
    // inclusive both ends of the range
    assign inRange    = ctrlTwo[C2_RANGE] && (callAddr[7:1] >= addrOne[7:1])
                        && (callAddr[7:1] <= spanAddr[7:1]);
    assign anyHit     = addrValid && (primaryHit || spanHit || gcallHit
                        || secondHit || alertHit || inRange);
    // engine uses this to ack; flag is already set when it does
    assign addressMatched = anyHit;

    // transfer complete: set wins over the clears
    // a clear in the cycle of a new byte end would lose the
    // completion, so the set is given priority
    // reads one out of reset: no transfer is pending
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            xferDone <= RST_TCF;
        end else if (rxDataDone || txByteDone || anyHit) begin
            xferDone <= 1'b1;
        end else if (byteStart) begin
            xferDone <= 1'b0;
        end else if ((rdStrobe && regIdx == IDX_DATA && !ctrlOne[C1_TX])
                     || (hitWr(IDX_DATA) && ctrlOne[C1_TX])) begin
            xferDone <= 1'b0;
        end
    end

    // addressed-as-target and direction bit
    // set in the address cycle so software sees it before ack
    // a control one write in that same cycle loses to the match
    // direction follows the latest match only
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            targetHit <= 1'b0;
            dirBit    <= 1'b0;
        end else begin
            if (anyHit) begin
                targetHit <= 1'b1;
                dirBit    <= callAddr[0];
            end else if (anyWr(IDX_CTRL_ONE)) begin
                targetHit <= 1'b0;
            end
        end
    end

    // range flag, cleared by any control one write
    // any write clears, whatever the lane mask
    // span equality counts even with range matching off
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            rangeHit <= 1'b0;
        end else if (addrValid && (spanHit || inRange)) begin
            rangeHit <= 1'b1;
        end else if (anyWr(IDX_CTRL_ONE)) begin
            rangeHit <= 1'b0;
        end
    end

    // arbitration lost: only a one in bit 4 clears, zero keeps
    // a loss in the cycle of the clear keeps the flag up
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            arbFlag <= 1'b0;
        end else if (arbLost) begin
            arbFlag <= 1'b1;
        end else if (hitWr(IDX_STAT_ONE) && wb_dat_i[S1_ARBITRATION_LOST_FLAG]) begin
            arbFlag <= 1'b0;
        end
    end

    // pins cross two flops before anything reads them
    // only the second and third flops feed logic; the first may be
    // metastable
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            sclMeta <= 1'b1;
            sclSync <= 1'b1;
            sdaMeta <= 1'b1;
            sdaSync <= 1'b1;
            sclLast <= 1'b1;
            sdaLast <= 1'b1;
        end else begin
            sclMeta <= sclIn;
            sclSync <= sclMeta;
            sdaMeta <= sdaIn;
            sdaSync <= sdaMeta;
            sclLast <= sclSync;
            sdaLast <= sdaSync;
        end
    end

    // sda edge while scl stays high marks start or stop
    // needs scl high on two samples to ignore data changes
    // made right at an scl edge
    assign startSeen = sclSync && sclLast && sdaLast && !sdaSync;
    assign stopSeen  = sclSync && sclLast && !sdaLast && sdaSync;

    // bus busy tracks start and stop in any mode
    // a start seen while busy is a repeated start; stays set
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            busBusy <= 1'b0;
        end else if (startSeen) begin
            busBusy <= 1'b1;
        end else if (stopSeen) begin
            busBusy <= 1'b0;
        end
    end

    // dma request pulse, one cycle after its trigger
    // disable checked first so no request escapes a clear
    // in fast mode receive is left to software, so it is silent
    // branch order mirrors the enable and fast mode bits
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            dmaRequest <= 1'b0;
        end else if (!ctrlOne[C1_DMA]) begin
            dmaRequest <= 1'b0;
        end else if (!sysMgmt[SM_FAST_ACK_NACK_MODE]) begin
            dmaRequest <= rxDataDone || txByteDone
                          || (addrValid && (primaryHit || gcallHit));
        end else begin
            dmaRequest <= txByteDone;
        end
    end

    // wake holds until low-power mode is left; no bus clock needed
    // runs on the module clock alone, the bus clock may be off
    // disable drops a pending wake at once
    // a wake bit cleared while asleep cancels the request
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            wakeRequest <= 1'b0;
        end else if (!lowPower) begin
            wakeRequest <= 1'b0;
        end else if (anyHit && ctrlOne[C1_WAKE]) begin
            wakeRequest <= 1'b1;
        end else if (!ctrlOne[C1_WAKE]) begin
            wakeRequest <= 1'b0;
        end
    end

    // limitation: the shift engine must pulse addrValid once per
    // address byte; a repeated pulse sets the flags again,
    // and with fast_ack_nack_mode 0 each primary or general-call pulse raises a dma request

endmodule
`default_nettype wire

// ### testbench/i2c_status_chk.sv
`timescale 1ns/1ps
`default_nettype none
module i2c_status_chk
    import i2c_status_pkg::*;
(
    input wire logic        sys_clk,
    input wire logic        srst,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [5:0]  wb_adr_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic        rxDataDone,
    input wire logic        txByteDone,
    input wire logic        addressMatched,
    input wire logic        lowPower,
    input wire logic        fastAckMode,
    input wire logic        dmaRequest,
    input wire logic        txLoad,
    input wire logic        wakeRequest
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (srst);
    logic dmaOn;
    logic wakeOn;
    // shadow of the control bits; the register itself is not visible here
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            dmaOn  <= 1'b0;
            wakeOn <= 1'b0;
        end else if (wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i && wb_sel_i[0]
                     && wb_adr_i == {2'b00, IDX_CTRL_ONE}) begin
            dmaOn  <= wb_dat_i[C1_DMA];
            wakeOn <= wb_dat_i[C1_WAKE];
        end
    end
    sequence busReq;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence busAns;
        wb_ack_o ##1 !wb_ack_o;
    endsequence
    chk_ack_timing: assert property (busReq |=> busAns)
        else $error("bus answer late or not a single pulse");
    chk_read_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("read data outside the answer cycle");
    chk_dma_off: assert property (!dmaOn |=> !dmaRequest)
        else $error("dma request while disabled");
    chk_dma_rx: assert property (dmaOn && !fastAckMode && rxDataDone |=> dmaRequest)
        else $error("no dma request after receive");
    chk_dma_tx: assert property (dmaOn && txByteDone |=> dmaRequest)
        else $error("no dma request after transmit");
    chk_dma_fast_ack_nack_mode: assert property (fastAckMode && !txByteDone |=> !dmaRequest)
        else $error("dma request in fast mode without transmit");
    chk_wake_on: assert property (lowPower && wakeOn && addressMatched |=> wakeRequest)
        else $error("no wake on match");
    chk_wake_off: assert property (!wakeOn |=> !wakeRequest)
        else $error("wake while disabled");
    chk_tx_load: assert property (busReq ##0 (wb_we_i && wb_sel_i[0]
        && wb_adr_i == {2'b00, IDX_DATA}) |=> txLoad)
        else $error("no load pulse after data write");
endmodule
`default_nettype wire

// ### testbench/i2c_bus_partner.sv
`timescale 1ns/1ps
`default_nettype none
module i2c_bus_partner (
    output logic sclLine,
    output logic sdaLine
);
    localparam time HALF = 40ns;
    // idle high through pull-ups; clock stands still between frames
    initial begin
        sclLine = 1'b1;
        sdaLine = 1'b1;
    end
    // odd first delay keeps edges off the system clock phase
    task automatic startCond();
        #13 sdaLine = 1'b0;
        #HALF sclLine = 1'b0;
    endtask
    task automatic stopCond();
        #HALF sclLine = 1'b1;
        #HALF sdaLine = 1'b1;
    endtask
endmodule
`default_nettype wire

// ### testbench/i2c_status_dma_wakeup_flags_tb.sv
`timescale 1ns/1ps
`default_nettype none
module i2c_status_dma_wakeup_flags_tb;
    import i2c_status_pkg::*;
    localparam logic [4:0] BS = 5'h10, AV = 5'h08, RX = 5'h04, TX = 5'h02, AL = 5'h01;
    // ctrl two, sys mgmt, calling address, expected status
    localparam logic [31:0] ROWS [8] = '{32'h000051C4, 32'h000058C8, 32'h800000C0, 32'h00000000,
                                         32'h004018C0, 32'h002031C4, 32'h080054C8, 32'h00005400};
    logic        sys_clk = 1'b0;
    logic        srst = 1'b1;
    logic        wbCyc = 1'b0, wbStb = 1'b0, wbWe = 1'b0, wbAck;
    logic [5:0]  wbAdr = 6'h00;
    logic [31:0] wbDatIn = 32'h0, wbDatOut;
    logic        byteStart = 1'b0, addrValid = 1'b0, rxDataDone = 1'b0, txByteDone = 1'b0;
    logic        arbLost = 1'b0, lowPower = 1'b0, sclLine, sdaLine, dmaRequest, wakeRequest;
    logic [7:0]  callAddr = 8'h00, txData, prevStat = 8'h00;
    int          miscompares = 0, numChecks = 0, cycles = 0, dmaCount = 0;
    always #5 sys_clk = ~sys_clk;
    i2c_bus_partner link (.sclLine(sclLine), .sdaLine(sdaLine));
    i2c_status_dma_wakeup_flags dut (.sys_clk(sys_clk), .srst(srst), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb),
        .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(4'h1), .wb_dat_i(wbDatIn), .wb_dat_o(wbDatOut),
        .wb_ack_o(wbAck), .sclIn(sclLine), .sdaIn(sdaLine), .byteStart(byteStart), .addrValid(addrValid),
        .callAddr(callAddr), .rxDataDone(rxDataDone), .txByteDone(txByteDone), .arbLost(arbLost),
        .rxData(8'hA5), .moduleIrq(1'b0), .receivedAck(1'b0), .lowPower(lowPower), .txData(txData),
        .txLoad(), .transmitMode(), .moduleEnable(), .fastAckMode(), .addressMatched(),
        .dmaRequest(dmaRequest), .wakeRequest(wakeRequest));
    // count request pulses; hang guard
    always @(posedge sys_clk) begin
        dmaCount <= dmaCount + (dmaRequest === 1'b1);
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            miscompares++;
            print_verdict();
        end
    end
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        numChecks++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic print_verdict();
        if (miscompares == 0 && numChecks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // one classic cycle, held until ack is sampled
    task automatic xfer(input logic w, input logic [3:0] idx, input logic [7:0] d, output logic [7:0] q);
        @(posedge sys_clk);
        wbCyc <= 1'b1;
        wbStb <= 1'b1;
        wbWe <= w;
        wbAdr <= {2'b00, idx};
        wbDatIn <= {24'h0, d};
        do @(posedge sys_clk); while (wbAck !== 1'b1);
        q = wbDatOut[7:0];
        wbCyc <= 1'b0;
        wbStb <= 1'b0;
    endtask
    task automatic wr(input logic [3:0] idx, input logic [7:0] d);
        logic [7:0] q;
        xfer(1'b1, idx, d, q);
    endtask
    task automatic rdChk(input logic [3:0] idx, input logic [7:0] exp);
        logic [7:0] q;
        xfer(1'b0, idx, 8'h00, q);
        check(q, exp);
    endtask
    // one-cycle engine pulses
    task automatic ev(input logic [4:0] e);
        @(posedge sys_clk);
        {byteStart, addrValid, rxDataDone, txByteDone, arbLost} <= e;
        @(posedge sys_clk);
        {byteStart, addrValid, rxDataDone, txByteDone, arbLost} <= 5'h00;
    endtask
    initial begin
        repeat (16) @(posedge sys_clk);
        srst <= 1'b0;
        rdChk(IDX_STAT_ONE, 8'h80);
        rdChk(4'h8, 8'h00);
        wr(IDX_ADDR_ONE, 8'h50);
        wr(IDX_ADDR_TWO, 8'h30);
        wr(IDX_SPAN, 8'h58);
        foreach (ROWS[i]) begin
            wr(IDX_CTRL_TWO, ROWS[i][31:24]);
            wr(IDX_SYS_MGMT, ROWS[i][23:16]);
            wr(IDX_CTRL_ONE, 8'h80);
            ev(BS);
            rdChk(IDX_STAT_ONE, prevStat & 8'h04);
            callAddr <= ROWS[i][15:8];
            ev(AV);
            rdChk(IDX_STAT_ONE, ROWS[i][7:0]);
            prevStat = ROWS[i][7:0];
        end
        callAddr <= 8'h58;
        ev(AV);
        wr(IDX_CTRL_ONE, 8'h80);
        rdChk(IDX_STAT_ONE, 8'h80);
        rdChk(IDX_DATA, 8'hA5);
        rdChk(IDX_STAT_ONE, 8'h00);
        wr(IDX_CTRL_ONE, 8'h90);
        ev(TX);
        rdChk(IDX_STAT_ONE, 8'h80);
        wr(IDX_DATA, 8'h3C);
        check(txData, 8'h3C);
        rdChk(IDX_STAT_ONE, 8'h00);
        ev(AL);
        wr(IDX_STAT_ONE, 8'hEF);
        rdChk(IDX_STAT_ONE, 8'h10);
        wr(IDX_STAT_ONE, 8'h10);
        rdChk(IDX_STAT_ONE, 8'h00);
        link.startCond();
        rdChk(IDX_STAT_ONE, 8'h20);
        link.stopCond();
        repeat (6) @(posedge sys_clk);
        rdChk(IDX_STAT_ONE, 8'h00);
        // fast mode off: receive, transmit, primary match all request
        wr(IDX_SYS_MGMT, 8'h00);
        wr(IDX_CTRL_ONE, 8'h81);
        callAddr <= 8'h50;
        ev(RX);
        ev(TX);
        ev(AV);
        wr(IDX_SYS_MGMT, 8'h80);
        ev(RX);
        ev(TX);
        lowPower <= 1'b1;
        wr(IDX_CTRL_ONE, 8'h82);
        ev(AV);
        @(posedge sys_clk);
        check(wakeRequest, 1'b1);
        wr(IDX_CTRL_ONE, 8'h80);
        ev(AV);
        @(posedge sys_clk);
        check(wakeRequest, 1'b0);
        check(dmaCount, 4);
        print_verdict();
    end
endmodule
bind i2c_status_dma_wakeup_flags i2c_status_chk chk (.sys_clk, .srst, .wb_cyc_i, .wb_stb_i, .wb_we_i,
    .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .rxDataDone, .txByteDone, .addressMatched,
    .lowPower, .fastAckMode, .dmaRequest, .txLoad, .wakeRequest);
`default_nettype wire
